// [design/aas_sequencer.sv]
`timescale 1ns/1ps
// Annunciator panel: several windows sharing four pushbuttons and one horn
module aas_sequencer #(
  parameter int N_WIN = 4,
  parameter int N_IN = 2,
  parameter int FAST_HALF_CYC = aas_pkg::AAS_FAST_HALF_CYC,
  parameter int SLOW_HALF_CYC = aas_pkg::AAS_SLOW_HALF_CYC,
  parameter int DEB_CYC = aas_pkg::AAS_DEB_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N_WIN*N_IN-1:0] field_in, // Active high, asynchronous
  input wire logic btn_silence,
  input wire logic btn_ack,
  input wire logic btn_reset,
  input wire logic btn_test,
  output logic [N_WIN-1:0] lamp_on,
  output logic alarm_on,
  output logic ringback_on,
  output logic test_active
);

  localparam int CW = 32;

  initial begin
    if (N_WIN < 1 || N_IN < 1) begin
      $error("aas_sequencer needs at least one window and input");
    end
    if (FAST_HALF_CYC < 1 || SLOW_HALF_CYC < 1 || DEB_CYC < 1) begin
      $error("aas_sequencer timing counts must be at least one");
    end
  end

  // Two-stage synchronisers for pins
  logic [N_WIN*N_IN-1:0] fin_s1;
  logic [N_WIN*N_IN-1:0] fin_s2;
  logic [3:0] btn_s1;
  logic [3:0] btn_s2;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fin_s1 <= '0;
      fin_s2 <= '0;
      btn_s1 <= 4'h0;
      btn_s2 <= 4'h0;
    end else begin
      fin_s1 <= field_in;
      fin_s2 <= fin_s1;
      btn_s1 <= {btn_test, btn_reset, btn_ack, btn_silence};
      btn_s2 <= btn_s1;
    end
  end

  // Debounce: a button level is accepted once stable for DEB_CYC cycles
  logic [3:0] btn_db;
  logic [CW-1:0] deb_cnt [4];
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (sys_rst) begin
        deb_cnt[i] <= '0;
        btn_db[i] <= aas_pkg::AAS_RST_BIT;
      end else if (btn_s2[i] == btn_db[i]) begin
        deb_cnt[i] <= '0;
      end else if (deb_cnt[i] >= CW'(DEB_CYC - 1)) begin
        deb_cnt[i] <= '0;
        btn_db[i] <= btn_s2[i];
      end else begin
        deb_cnt[i] <= deb_cnt[i] + CW'(1);
      end
    end
  end

  // Press pulses, one cycle on the debounced rising edge
  logic [3:0] btn_prev;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      btn_prev <= 4'h0;
    end else begin
      btn_prev <= btn_db;
    end
  end
  wire [3:0] press = btn_db & ~btn_prev;
  wire testing = btn_db[3];
  // (RL11) presses during test are dropped so operator buttons cannot move stored state under a masked display
  wire silence_p = press[0] & ~testing;
  wire ack_p = press[1] & ~testing;
  wire reset_p = press[2] & ~testing;

  // Flash generator shared by all windows, so panel flashes stay in step
  function automatic logic [CW-1:0] tick_next(input logic [CW-1:0] c, input int half);
    tick_next = (c >= CW'(half - 1)) ? '0 : c + CW'(1);
  endfunction
  logic [CW-1:0] fast_cnt;
  logic [CW-1:0] slow_cnt;
  logic fast_ph;
  logic slow_ph;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fast_cnt <= '0;
      slow_cnt <= '0;
      fast_ph <= 1'h0;
      slow_ph <= 1'h0;
    end else begin
      fast_cnt <= tick_next(fast_cnt, FAST_HALF_CYC);
      slow_cnt <= tick_next(slow_cnt, SLOW_HALF_CYC);
      if (fast_cnt >= CW'(FAST_HALF_CYC - 1)) begin
        fast_ph <= ~fast_ph;
      end
      if (slow_cnt >= CW'(SLOW_HALF_CYC - 1)) begin
        slow_ph <= ~slow_ph;
      end
    end
  end

  // Window sequencers
  logic [1:0] lamp_pat [N_WIN];
  logic [N_WIN-1:0] alarm_req;
  logic [N_WIN-1:0] ring_req;
  logic [N_WIN-1:0] next_lamp;
  genvar w;
  generate
    for (w = 0; w < N_WIN; w++) begin : g_win
      aas_window #(.N_IN(N_IN)) u_win (
        .clk(clk),
        .sys_rst(sys_rst),
        .trip(fin_s2[w*N_IN +: N_IN]),
        .silence_p(silence_p),
        .ack_p(ack_p),
        .reset_p(reset_p),
        .state(),
        .lamp(lamp_pat[w]),
        .alarm_req(alarm_req[w]),
        .ring_req(ring_req[w])
      );
      // (RL11)(RL12) test overrides display only; release shows stored state again
      assign next_lamp[w] = testing ? fast_ph :
                            (lamp_pat[w] == aas_pkg::AAS_LAMP_FAST) ? fast_ph :
                            (lamp_pat[w] == aas_pkg::AAS_LAMP_SLOW) ? slow_ph :
                            (lamp_pat[w] == aas_pkg::AAS_LAMP_STEADY);
    end
  endgenerate

  // (RL10) alarm wins over ring-back
  wire next_alarm = testing | (|alarm_req);
  wire next_ring = ~next_alarm & (|ring_req);

  // Registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lamp_on <= '0;
      alarm_on <= 1'h0;
      ringback_on <= 1'h0;
      test_active <= 1'h0;
    end else begin
      lamp_on <= next_lamp;
      alarm_on <= next_alarm;
      ringback_on <= next_ring;
      test_active <= testing;
    end
  end

endmodule

// [design/aas_pkg.sv]
// Contract
// (RL1) Pushbuttons act only in the order silence, acknowledge, reset; other presses do nothing.
// (RL2) While an alert is active and unsilenced, acknowledge and reset do nothing.
// (RL3) A silenced, unacknowledged active alert ignores reset: fast flash, both audibles off.
// (RL4) An input clearing before silence leaves the window latched in fast flash with alarm on.
// (RL5) For an input that cleared before silence, acknowledge or reset before silence are ignored.
// (RL6) An input clearing after silence but before acknowledge keeps fast flash, audibles off.
// (RL7) For an input that cleared after silence but before acknowledge, reset changes nothing.
// (RL8) An acknowledged window with normal input shows slow flash and ring-back; reset clears it.
// (RL9) Acknowledge after silence with the input already clear gives slow flash and ring-back.
// (RL10) With alarm and ring-back both requested, the alarm sounds and ring-back is suppressed.
// (RL11) Test drives every window to fast flash with the alarm on without touching stored state.
// (RL12) On release of test, the windows show again what they showed before the test.
// (RL13) On a multi-input window, a tripped and acknowledged input gives steady on.
// (RL14) On a multi-input window, another input tripping later brings back fast flash and alarm.
// (RL15) No alert: all off; alert: fast flash, alarm; silence stops alarm; ack then gives steady.
package aas_pkg;

  // Window sequence states, one-hot
  typedef enum logic [5:0] {
    AAS_NORMAL = 6'h01, // Lamp off, quiet
    AAS_ALERT = 6'h02, // Fast flash, alarm
    AAS_SILENCED = 6'h04, // Fast flash, quiet
    AAS_ACKED = 6'h08, // Steady on
    AAS_RINGBACK = 6'h10 // Slow flash, ring-back
  } aas_state_t;

  // Lamp patterns
  localparam logic [1:0] AAS_LAMP_OFF = 2'h0;
  localparam logic [1:0] AAS_LAMP_FAST = 2'h1;
  localparam logic [1:0] AAS_LAMP_SLOW = 2'h2;
  localparam logic [1:0] AAS_LAMP_STEADY = 2'h3;

  // Clock and flash timing
  localparam int AAS_CLK_HZ = 200_000_000;
  localparam int AAS_FAST_HALF_MS = 250;
  localparam int AAS_SLOW_HALF_MS = 1000;
  localparam int AAS_FAST_HALF_CYC = AAS_CLK_HZ / 1000 * AAS_FAST_HALF_MS;
  localparam int AAS_SLOW_HALF_CYC = AAS_CLK_HZ / 1000 * AAS_SLOW_HALF_MS;

  // Button debounce hold, microseconds
  localparam int AAS_DEB_US = 10;
  localparam int AAS_DEB_CYC = AAS_CLK_HZ / 1_000_000 * AAS_DEB_US;

  // Reset values
  localparam logic AAS_RST_BIT = 1'h0;

endpackage

// [design/aas_window.sv]
`timescale 1ns/1ps
// One annunciator window sequencer
module aas_window #(
  parameter int N_IN = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N_IN-1:0] trip, // Synchronised field inputs
  input wire logic silence_p,
  input wire logic ack_p,
  input wire logic reset_p,
  output aas_pkg::aas_state_t state,
  output logic [1:0] lamp,
  output logic alarm_req,
  output logic ring_req
);

  initial begin
    if (N_IN < 1) begin
      $error("aas_window needs at least one input");
    end
  end

  aas_pkg::aas_state_t next_state;
  logic [N_IN-1:0] seen; // Inputs already announced
  logic [N_IN-1:0] next_seen;
  wire any_active = |trip;
  // Rising edge on an input not yet announced
  wire new_trip = |(trip & ~seen);

  // Marks drop with the input, so a contact that returns is announced again
  assign next_seen = (state == aas_pkg::AAS_NORMAL && !new_trip) ? '0 : trip;

  // (RL1) Sequence order kept
  // Out-of-order presses fall through unchanged
  always_comb begin
    next_state = state;
    case (state)
      aas_pkg::AAS_NORMAL: begin
        if (new_trip) begin
          next_state = aas_pkg::AAS_ALERT;
        end
      end
      aas_pkg::AAS_ALERT: begin
        // (RL2) only silence is honoured; (RL4)(RL5) latched even if input clears
        if (silence_p) begin
          next_state = aas_pkg::AAS_SILENCED;
        end
      end
      aas_pkg::AAS_SILENCED: begin
        // (RL14) another trip resounds alarm
        if (new_trip) begin
          next_state = aas_pkg::AAS_ALERT;
        // (RL3)(RL7) reset ignored; (RL9)(RL6) ack picks steady or ring-back
        end else if (ack_p) begin
          next_state = any_active ? aas_pkg::AAS_ACKED : aas_pkg::AAS_RINGBACK;
        end
      end
      aas_pkg::AAS_ACKED: begin
        // (RL14) second input trips
        if (new_trip) begin
          next_state = aas_pkg::AAS_ALERT;
        end else if (!any_active) begin
          next_state = aas_pkg::AAS_RINGBACK;
        end
      end
      aas_pkg::AAS_RINGBACK: begin
        if (new_trip) begin
          next_state = aas_pkg::AAS_ALERT;
        // (RL8) reset clears a cleared, acknowledged window
        end else if (reset_p) begin
          next_state = aas_pkg::AAS_NORMAL;
        end
      end
      default: next_state = aas_pkg::AAS_NORMAL;
    endcase
  end

  // (RL15)(RL13) state to lamp and audible requests
  assign lamp = (state == aas_pkg::AAS_ALERT || state == aas_pkg::AAS_SILENCED) ?
                aas_pkg::AAS_LAMP_FAST :
                (state == aas_pkg::AAS_ACKED) ? aas_pkg::AAS_LAMP_STEADY :
                (state == aas_pkg::AAS_RINGBACK) ? aas_pkg::AAS_LAMP_SLOW :
                aas_pkg::AAS_LAMP_OFF;
  assign alarm_req = (state == aas_pkg::AAS_ALERT);
  assign ring_req = (state == aas_pkg::AAS_RINGBACK);

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= aas_pkg::AAS_NORMAL;
      seen <= '0;
    end else begin
      state <= next_state;
      seen <= next_seen;
    end
  end

endmodule

// [tb/aas_checker.sv]
`timescale 1ns/1ps
// Port-level watch on the panel outputs
module aas_checker #(
  parameter int N_WIN = 2,
  parameter int N_IN = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [N_WIN*N_IN-1:0] field_in,
  input wire logic btn_silence,
  input wire logic btn_ack,
  input wire logic btn_reset,
  input wire logic btn_test,
  input wire logic [N_WIN-1:0] lamp_on,
  input wire logic alarm_on,
  input wire logic ringback_on,
  input wire logic test_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Tone priority and quiet start
  audio_excl_a: assert property (!(alarm_on && ringback_on))
    else $error("both tones on");
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !alarm_on && !ringback_on && !(|lamp_on))
    else $error("not quiet after reset");
  // Test overrides the display in step; eight cycles cover sync and debounce
  test_alarm_a: assert property (
    test_active[*2] |-> alarm_on && !ringback_on)
    else $error("test tone wrong");
  test_lamps_a: assert property (
    test_active[*2] |-> &lamp_on || !(|lamp_on))
    else $error("test lamps differ");
  test_enter_a: assert property (btn_test[*8] |-> test_active)
    else $error("test not entered");
  test_leave_a: assert property ((!btn_test)[*8] |-> !test_active)
    else $error("test not left");
  // Alarm stops only for silence or the end of a test
  alarm_hold_a: assert property (
    (alarm_on && !btn_silence && !btn_test && !test_active)[*8] |=> alarm_on)
    else $error("alarm dropped");
  ack_ignored_a: assert property (
    alarm_on && btn_ack && !btn_silence && !btn_test && !test_active |=> alarm_on)
    else $error("ack stopped alarm");
  alarm_stop_a: assert property (
    $fell(alarm_on) && !$fell(test_active) |-> $past(btn_silence, 3))
    else $error("alarm stopped unasked");
  // Ring-back holds until reset, a new trip or a test
  ring_hold_a: assert property (
    (ringback_on && !btn_reset && !btn_test && !test_active && !(|field_in))[*8] |=> ringback_on)
    else $error("ringback dropped");
endmodule
bind aas_sequencer aas_checker #(.N_WIN(N_WIN), .N_IN(N_IN)) chk_i (.clk(clk), .sys_rst(sys_rst),
  .field_in(field_in), .btn_silence(btn_silence), .btn_ack(btn_ack), .btn_reset(btn_reset),
  .btn_test(btn_test), .lamp_on(lamp_on), .alarm_on(alarm_on), .ringback_on(ringback_on),
  .test_active(test_active));

// [tb/aas_panel.sv]
`timescale 1ns/1ps
// Field contacts and operator pushbuttons
module aas_panel #(
  parameter int NB = 4
) (
  input wire logic clk,
  output logic [NB-1:0] field_in,
  output logic btn_silence,
  output logic btn_ack,
  output logic btn_reset,
  output logic btn_test
);
  logic [3:0] btn = 4'h0;
  initial field_in = '0;
  // Buttons held as plain levels, bounce not modelled
  assign {btn_test, btn_reset, btn_ack, btn_silence} = btn;
  task trip(input int i, input logic v);
    @(negedge clk) field_in[i] = v;
    repeat (8) @(negedge clk);
  endtask
  // Wait long enough for debounce and state update
  task set(input int b, input logic v);
    @(negedge clk) btn[b] = v;
    repeat (10) @(negedge clk);
  endtask
  task push(input int b);
    set(b, 1'b1);
    set(b, 1'b0);
  endtask
endmodule

// [tb/tb_annunciator_alarm_sequencer.sv]
`timescale 1ns/1ps
module tb_annunciator_alarm_sequencer;
  localparam int SIL = 0, ACK = 1, RST = 2, TST = 3;
  localparam logic [3:0] FA = {aas_pkg::AAS_LAMP_FAST, 2'h2}, FQ = {aas_pkg::AAS_LAMP_FAST, 2'h0};
  localparam logic [3:0] ST = {aas_pkg::AAS_LAMP_STEADY, 2'h0};
  localparam logic [3:0] SR = {aas_pkg::AAS_LAMP_SLOW, 2'h1};
  localparam logic [3:0] OF = {aas_pkg::AAS_LAMP_OFF, 2'h0}, SA = {aas_pkg::AAS_LAMP_SLOW, 2'h2};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic [3:0] field_in;
  wire logic btn_silence, btn_ack, btn_reset, btn_test;
  logic [1:0] lamp_on;
  logic alarm_on, ringback_on, test_active;
  int bad_count = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  // Short flash and debounce counts keep the run brief
  aas_sequencer #(.N_WIN(2), .N_IN(2), .FAST_HALF_CYC(4), .SLOW_HALF_CYC(8), .DEB_CYC(2)) DUT (
    .clk(clk), .sys_rst(sys_rst), .field_in(field_in), .btn_silence(btn_silence),
    .btn_ack(btn_ack), .btn_reset(btn_reset), .btn_test(btn_test), .lamp_on(lamp_on),
    .alarm_on(alarm_on), .ringback_on(ringback_on), .test_active(test_active));
  aas_panel P (.clk(clk), .field_in(field_in), .btn_silence(btn_silence), .btn_ack(btn_ack),
    .btn_reset(btn_reset), .btn_test(btn_test));
  task conclude;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classify the lamp by toggles over 16 cycles: fast toggles 3-4, slow 1-2
  task look(input int w, input logic [3:0] exp);
    int n;
    logic last;
    logic [1:0] c;
    n = 0;
    last = lamp_on[w];
    repeat (16) begin
      @(negedge clk);
      if (lamp_on[w] !== last) n++;
      last = lamp_on[w];
    end
    c = n > 2 ? aas_pkg::AAS_LAMP_FAST : n > 0 ? aas_pkg::AAS_LAMP_SLOW :
        last === 1'b1 ? aas_pkg::AAS_LAMP_STEADY : aas_pkg::AAS_LAMP_OFF;
    chk({c, alarm_on, ringback_on}, exp);
  endtask
  task t_order;
    P.trip(0, 1'b1);
    look(0, FA);
    P.push(ACK);
    look(0, FA);
    P.push(RST);
    look(0, FA);
    P.push(SIL);
    look(0, FQ);
    P.push(RST);
    look(0, FQ);
    P.push(ACK);
    look(0, ST);
    P.trip(0, 1'b0);
    look(0, SR);
    P.push(RST);
    look(0, OF);
    $display("order done");
  endtask
  task t_early;
    P.trip(0, 1'b1);
    P.trip(0, 1'b0);
    look(0, FA);
    P.push(ACK);
    P.push(RST);
    look(0, FA);
    P.push(SIL);
    look(0, FQ);
    P.push(ACK);
    look(0, SR);
    P.push(RST);
    look(0, OF);
    $display("early clear done");
  endtask
  task t_mid;
    P.trip(2, 1'b1);
    P.push(SIL);
    P.trip(2, 1'b0);
    look(1, FQ);
    P.push(RST);
    look(1, FQ);
    P.push(ACK);
    look(1, SR);
    P.push(RST);
    look(1, OF);
    $display("late clear done");
  endtask
  task t_multi;
    P.trip(0, 1'b1);
    P.push(SIL);
    P.push(ACK);
    look(0, ST);
    P.trip(1, 1'b1);
    look(0, FA);
    P.push(SIL);
    P.push(ACK);
    P.trip(0, 1'b0);
    P.trip(1, 1'b0);
    look(0, SR);
    P.push(RST);
    look(0, OF);
    $display("multi input done");
  endtask
  task t_test;
    P.trip(2, 1'b1);
    P.push(SIL);
    P.push(ACK);
    P.trip(2, 1'b0);
    P.set(TST, 1'b1);
    chk({3'h0, test_active}, 4'h1);
    look(0, FA);
    look(1, FA);
    P.set(TST, 1'b0);
    chk({3'h0, test_active}, 4'h0);
    look(1, SR);
    P.trip(0, 1'b1);
    look(1, SA);
    P.push(SIL);
    P.push(ACK);
    P.trip(0, 1'b0);
    P.push(RST);
    look(0, OF);
    look(1, OF);
    $display("test button done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_order();
    t_early();
    t_mid();
    t_multi();
    t_test();
    conclude();
  end
  // Whole run needs about 1100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule
